// [hdl/segment_lcd_defines.svh]
// Offsets, field positions, masks and counts of the segment LCD control block
`ifndef SEGMENT_LCD_DEFINES_SVH
`define SEGMENT_LCD_DEFINES_SVH

// ==========================================================
// Register byte addresses
`define LCD_ADDR_MAIN       4'h0
`define LCD_ADDR_PUMP       4'h4
`define LCD_ADDR_DUTY       4'h8

// ==========================================================
// Implemented-bit masks and reset values
`define LCD_MASK_MAIN       8'hf7
`define LCD_MASK_PUMP       8'h0b
`define LCD_MASK_DUTY       8'he7
`define LCD_RESET_VALUE     8'h00

// ==========================================================
// Field positions
`define LCD_BIT_WAVE_TYPE   7
`define LCD_BIT_BIAS_STYLE  6
`define LCD_BIT_CSRC_HI     5
`define LCD_BIT_CSRC_LO     4
`define LCD_BIT_RCUR_HI     2
`define LCD_BIT_RCUR_LO     1
`define LCD_BIT_ENABLE      0
`define LCD_BIT_RSUPPLY     3
`define LCD_BIT_PVOLT_HI    1
`define LCD_BIT_PVOLT_LO    0
`define LCD_BIT_PDIV_HI     7
`define LCD_BIT_PDIV_LO     5
`define LCD_BIT_DUTY_HI     2
`define LCD_BIT_DUTY_LO     1
`define LCD_BIT_BIAS_RATIO  0

// ==========================================================
// Duty codes, common counts and clock divisions
`define LCD_DUTY_QUARTER    2'h0
`define LCD_DUTY_SIXTH      2'h1
`define LCD_DUTY_EIGHTH     2'h2
`define LCD_COMS_QUARTER    4'h4
`define LCD_COMS_SIXTH      4'h6
`define LCD_COMS_EIGHTH     4'h8
`define LCD_SUB_DIVIDE      8
`define LCD_PDIV_LAST       3'h6
`define LCD_AXI_OKAY        2'h0
`define LCD_AXI_SLVERR      2'h2

`endif

// [hdl/segment_lcd_pkg.sv]
// Types shared by the segment LCD control block
package segment_lcd_pkg;

  // ==========================================================
  // Decoded settings for the analog bias generator
  typedef struct packed {
    logic       wave_type_b;
    logic       cbias_selected;
    logic [1:0] cbias_power_source;
    logic [1:0] rbias_current_select;
    logic       rbias_supply_select;
    logic       rpump_enable;
    logic       cpump_enable;
    logic [1:0] pump_voltage_select;
    logic       bias_quarter;
  } bias_ctrl_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b01,
    SEQ_RUN = 2'b10
  } seq_state_t;

endpackage

// [hdl/lcd_tick_divider.sv]
// Divides a stream of one-cycle ticks by a fixed ratio
`timescale 1ns/10ps
module lcd_tick_divider #(
  parameter int DIV = 8
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  input  wire logic tick_in,
  output logic      tick_out
);

  logic [$clog2(DIV)-1:0] count_r;

  // ==========================================================
  // Counter
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_r  <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_r == ($clog2(DIV))'(DIV - 1)) begin
          count_r  <= '0;
          tick_out <= 1'b1;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

endmodule // lcd_tick_divider

// [hdl/lcd_pump_clock.sv]
// Selectable divider that makes the capacitor pump clock
`timescale 1ns/10ps
`include "segment_lcd_defines.svh"
module lcd_pump_clock (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       sub_tick,
  input  wire logic [2:0] divider_sel,
  output logic            pump_clk
);

  logic [5:0] count_r;
  logic [2:0] code;
  logic [5:0] half_last;

  // Code 7 behaves as code 6
  assign code      = (divider_sel > `LCD_PDIV_LAST) ? `LCD_PDIV_LAST : divider_sel;
  assign half_last = 6'((7'h40 >> code) - 7'h01);

  // ==========================================================
  // Half-period counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      count_r  <= '0;
      pump_clk <= 1'b0;
    end else if (sub_tick) begin
      if (count_r >= half_last) begin
        count_r  <= '0;
        pump_clk <= ~pump_clk;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

endmodule // lcd_pump_clock

// [hdl/segment_lcd_control_regs.sv]
// Segment LCD control registers with bus slave, bias decode and sequencer
`timescale 1ns/10ps
`include "segment_lcd_defines.svh"
// How it works
// (RL1) Main register bit 7 picks waveform Type A (0) or Type B (1).
// (RL2) Main register bit 6 picks resistor (0) or charge-pump (1) biasing.
// (RL3) Bits 5:4 pick pump power: pins, reference on VC, 3V on VB, supply on VA.
// (RL4) Bits 2:1 pick resistor bias current 25, 50, 100 or 200 uA.
// (RL5) Software keeps bias current at 00 while pump biasing is chosen.
// (RL6) Main bit 0 enables the display in fast, slow and idle modes.
// (RL7) Sleep mode forces the driver off regardless of enable.
// (RL8) Pump register bit 3 picks supply pin (0) or internal pump (1).
// (RL9) Resistor pump is off if supply bit 0, pump biasing, or disabled.
// (RL10) Pump bits 1:0 pick 3.3V, 3.0V, 2.7V or 4.5V.
// (RL11) Duty bits 7:5 divide the 32kHz clock by 128 down to 2; 111 is 2.
// (RL12) Duty bits 2:1 select four, six or eight commons; 11 unimplemented.
// (RL13) Commons not used by the duty are released for other pin uses.
// (RL14) Duty bit 0 picks 1/3 (0) or 1/4 (1) bias.
// (RL15) Unimplemented bits read zero and ignore writes.
// (RL16) Pump biasing enables the capacitor charge pump.
// (RL17) Disabled or sleeping resets the function, commons and segments low.
// (RL18) Waveform logic steps on the sub clock divided by eight.
// (RL19) Reset clears all three registers, leaving the display off.
module segment_lcd_control_regs
  import segment_lcd_pkg::*;
#(
  parameter int SEG_N = 32,
  parameter int COM_N = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [3:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [3:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      sleep_mode,
  input  wire logic                      sub_clk,
  input  wire logic [SEG_N-1:0]          seg_data,
  output segment_lcd_pkg::bias_ctrl_t    bias_ctrl,
  output logic                           cpump_clk,
  output logic [COM_N-1:0]               com_drive,
  output logic [COM_N-1:0]               com_release,
  output logic [SEG_N-1:0]               seg_drive,
  output logic                           drive_polarity,
  output logic [2:0]                     com_index
);
  import segment_lcd_pkg::*;

  // ==========================================================
  // Register storage
  logic [7:0]  main_ctrl_r;
  logic [7:0]  pump_ctrl_r;
  logic [7:0]  duty_ctrl_r;
  logic [3:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        do_write;
  logic        aw_mapped;
  logic [7:0]  rd_value;
  logic        rd_mapped;

  // Both halves held and no answer pending
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    aw_mapped = (aw_addr_r == `LCD_ADDR_MAIN) || (aw_addr_r == `LCD_ADDR_PUMP) ||
                (aw_addr_r == `LCD_ADDR_DUTY);
  end

  // ==========================================================
  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr_r     <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // ==========================================================
  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data_r     <= 8'h00;
      w_lane0_r    <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_r     <= s_axi_wdata[7:0];
      w_lane0_r    <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ==========================================================
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LCD_AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_mapped ? `LCD_AXI_OKAY : `LCD_AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // (RL19) Cleared on reset
      main_ctrl_r <= `LCD_RESET_VALUE;
      pump_ctrl_r <= `LCD_RESET_VALUE;
      duty_ctrl_r <= `LCD_RESET_VALUE;
    end else if (do_write && w_lane0_r) begin
      // (RL15) Masked write storage
      unique case (aw_addr_r)
        `LCD_ADDR_MAIN: main_ctrl_r <= w_data_r & `LCD_MASK_MAIN;
        `LCD_ADDR_PUMP: pump_ctrl_r <= w_data_r & `LCD_MASK_PUMP;
        `LCD_ADDR_DUTY: duty_ctrl_r <= w_data_r & `LCD_MASK_DUTY;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    rd_value  = 8'h00;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      `LCD_ADDR_MAIN: rd_value = main_ctrl_r;
      `LCD_ADDR_PUMP: rd_value = pump_ctrl_r;
      `LCD_ADDR_DUTY: rd_value = duty_ctrl_r;
      default:        rd_mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LCD_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      // (RL15) Upper bits read zero
      s_axi_rdata   <= {24'h00_0000, rd_value};
      s_axi_rresp   <= rd_mapped ? `LCD_AXI_OKAY : `LCD_AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Field views
  logic       display_enable;
  logic       bias_style_select;
  logic       rbias_supply_select;
  logic [2:0] pump_clock_divider;
  logic [1:0] duty_select;
  logic       lcd_reset;

  assign display_enable      = main_ctrl_r[`LCD_BIT_ENABLE];
  assign bias_style_select   = main_ctrl_r[`LCD_BIT_BIAS_STYLE];
  assign rbias_supply_select = pump_ctrl_r[`LCD_BIT_RSUPPLY];
  assign pump_clock_divider  = duty_ctrl_r[`LCD_BIT_PDIV_HI:`LCD_BIT_PDIV_LO];
  assign duty_select         = duty_ctrl_r[`LCD_BIT_DUTY_HI:`LCD_BIT_DUTY_LO];
  // (RL6) (RL7) (RL17) Enable gated by sleep
  assign lcd_reset           = !display_enable || sleep_mode;

  // ==========================================================
  // Bias generator controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_ctrl <= '0;
    end else begin
      // (RL1) Waveform style
      bias_ctrl.wave_type_b          <= main_ctrl_r[`LCD_BIT_WAVE_TYPE];
      // (RL2) Bias style
      bias_ctrl.cbias_selected       <= bias_style_select;
      // (RL3) Pump power source
      bias_ctrl.cbias_power_source   <= main_ctrl_r[`LCD_BIT_CSRC_HI:`LCD_BIT_CSRC_LO];
      // (RL4) Resistor bias current; (RL5) software keeps it zero for pump bias
      bias_ctrl.rbias_current_select <= main_ctrl_r[`LCD_BIT_RCUR_HI:`LCD_BIT_RCUR_LO];
      // (RL8) Resistor supply source
      bias_ctrl.rbias_supply_select  <= rbias_supply_select;
      // (RL9) Resistor pump gating
      bias_ctrl.rpump_enable         <= rbias_supply_select && !bias_style_select &&
                                        display_enable && !sleep_mode;
      // (RL16) Capacitor pump on with pump bias
      bias_ctrl.cpump_enable         <= bias_style_select;
      // (RL10) Pump output voltage
      bias_ctrl.pump_voltage_select  <= pump_ctrl_r[`LCD_BIT_PVOLT_HI:`LCD_BIT_PVOLT_LO];
      // (RL14) Bias ratio
      bias_ctrl.bias_quarter         <= duty_ctrl_r[`LCD_BIT_BIAS_RATIO];
    end
  end

  // ==========================================================
  // Sub clock edge and dividers
  logic sub_clk_d_r;
  logic sub_tick;
  logic lcd_tick;

  // Pin is taken as synchronous; a single stage suffices for the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_clk_d_r <= 1'b0;
    end else begin
      sub_clk_d_r <= sub_clk;
    end
  end

  assign sub_tick = sub_clk && !sub_clk_d_r;

  // (RL18) Waveform step is sub clock over eight
  lcd_tick_divider #(
    .DIV      (`LCD_SUB_DIVIDE)
  ) u_lcd_tick (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (lcd_reset),
    .tick_in  (sub_tick),
    .tick_out (lcd_tick)
  );

  // (RL11) Pump clock from selected division
  lcd_pump_clock u_pump_clock (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (bias_style_select),
    .sub_tick    (sub_tick),
    .divider_sel (pump_clock_divider),
    .pump_clk    (cpump_clk)
  );

  // ==========================================================
  // Duty decode
  logic [3:0] com_count;

  // (RL12) Common count per duty; the unimplemented code falls back to four
  always_comb begin
    unique case (duty_select)
      `LCD_DUTY_SIXTH:  com_count = `LCD_COMS_SIXTH;
      `LCD_DUTY_EIGHTH: com_count = `LCD_COMS_EIGHTH;
      default:          com_count = `LCD_COMS_QUARTER;
    endcase
  end

  // (RL13) Unused commons released
  genvar gi;
  generate
    for (gi = 0; gi < COM_N; gi++) begin : g_release
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          com_release[gi] <= 1'b1;
        end else begin
          com_release[gi] <= (gi >= com_count);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Waveform sequencer
  seq_state_t state_r;
  logic       half_r;
  logic       frame_pol_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SEQ_OFF;
    end else begin
      unique case (state_r)
        SEQ_OFF: if (!lcd_reset) state_r <= SEQ_RUN;
        SEQ_RUN: if (lcd_reset)  state_r <= SEQ_OFF;
      endcase
    end
  end

  // Type A flips polarity inside each slot, Type B once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn || lcd_reset || state_r == SEQ_OFF) begin
      com_index   <= 3'h0;
      half_r      <= 1'b0;
      frame_pol_r <= 1'b0;
    end else if (lcd_tick) begin
      half_r <= ~half_r;
      if (half_r) begin
        if ({1'b0, com_index} >= com_count - 4'h1) begin
          com_index   <= 3'h0;
          frame_pol_r <= ~frame_pol_r;
        end else begin
          com_index <= com_index + 3'h1;
        end
      end
    end
  end

  // (RL17) Outputs low while held in reset
  always_ff @(posedge aclk) begin
    if (!aresetn || lcd_reset || state_r == SEQ_OFF) begin
      com_drive      <= '0;
      seg_drive      <= '0;
      drive_polarity <= 1'b0;
    end else begin
      com_drive      <= COM_N'(1) << com_index;
      seg_drive      <= seg_data;
      drive_polarity <= main_ctrl_r[`LCD_BIT_WAVE_TYPE] ? frame_pol_r : half_r;
    end
  end

endmodule // segment_lcd_control_regs

// [testbench/segment_lcd_control_regs_asserts.sv]
// Port checker for the segment LCD control registers
`timescale 1ns/10ps
module segment_lcd_control_regs_asserts
  import segment_lcd_pkg::*;
#(
  parameter int SEG_N = 32,
  parameter int COM_N = 8
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        sleep_mode,
  input wire segment_lcd_pkg::bias_ctrl_t bias_ctrl,
  input wire logic                        cpump_clk,
  input wire logic [COM_N-1:0]            com_drive,
  input wire logic [COM_N-1:0]            com_release,
  input wire logic [SEG_N-1:0]            seg_drive
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Bus answers
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  // ==========================================================
  // Bias and pump decode
  a_cpump_on: assert property (
    bias_ctrl.cpump_enable == bias_ctrl.cbias_selected)
    else $error("pump enable differs from bias style");
  a_rpump_gate: assert property (
    bias_ctrl.rpump_enable |-> bias_ctrl.rbias_supply_select && !bias_ctrl.cbias_selected)
    else $error("resistor pump on while gated");
  a_cpump_idle: assert property (
    (!bias_ctrl.cbias_selected) [*2] |-> !cpump_clk)
    else $error("pump clock runs under resistor bias");
  // ==========================================================
  // Common and segment outputs
  a_sleep_blank: assert property (
    sleep_mode |=> com_drive == '0 && seg_drive == '0 && !bias_ctrl.rpump_enable)
    else $error("outputs active in sleep");
  a_com_single: assert property ($onehot0(com_drive))
    else $error("more than one common active");
  a_release_low: assert property ($past(aresetn) |-> com_release[3:0] == 4'h0)
    else $error("first four commons released");
  a_release_apart: assert property (
    $changed(com_drive) && $stable(com_release) |-> (com_drive & com_release) == '0)
    else $error("released common driven");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_sleep: cover property (sleep_mode && com_drive != '0);
  c_pump: cover property ($rose(cpump_clk));
endmodule // segment_lcd_control_regs_asserts

bind segment_lcd_control_regs segment_lcd_control_regs_asserts #(
  .SEG_N(SEG_N), .COM_N(COM_N)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .bias_ctrl,
  .cpump_clk, .com_drive, .com_release, .seg_drive);

// [testbench/lcd_glass_model.sv]
// Glass model that watches the common scan order and dwell
`timescale 1ns/10ps
module lcd_glass_model #(
  parameter int COM_N = 8
) (
  input  wire logic             aclk,
  input  wire logic [COM_N-1:0] com_drive,
  output int                    seq_err,
  output int                    frame_coms,
  output int                    dwell
);
  logic [COM_N-1:0] prev_r;
  int               run_r;
  int               cnt_r;
  initial begin
    seq_err = 0;
    frame_coms = 0;
    dwell = 0;
    prev_r = '0;
    run_r = 0;
    cnt_r = 0;
  end
  // ==========================================================
  // Scan order, commons per frame, cycles per common
  always @(posedge aclk) begin
    prev_r <= com_drive;
    run_r <= (com_drive == prev_r) ? run_r + 1 : 1;
    if (com_drive != prev_r && com_drive != '0) begin
      if (prev_r != '0) dwell <= run_r;
      if (com_drive[0]) begin
        frame_coms <= cnt_r;
        cnt_r <= 1;
      end else begin
        cnt_r <= cnt_r + 1;
        if (com_drive != (prev_r << 1)) seq_err <= seq_err + 1;
      end
    end
  end
endmodule // lcd_glass_model

// [testbench/segment_lcd_control_regs_tb.sv]
// Self-checking bench for the segment LCD control registers
`timescale 1ns/10ps
`include "segment_lcd_defines.svh"
module segment_lcd_control_regs_tb;
  import segment_lcd_pkg::*;
  localparam int SUBP = 4;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sleep_mode, sub_clk, cpump_clk, drive_polarity;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, seg_data, seg_drive, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sub_cnt, resp;
  logic [7:0]  com_drive, com_release, v;
  logic [7:0]  regs [3];
  logic [2:0]  com_index;
  bias_ctrl_t  bias_ctrl;
  int          seed, bad_count, n_checks, seq_err, frame_coms, dwell, n, i;

  segment_lcd_control_regs #(.SEG_N(32), .COM_N(8)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .sub_clk,
    .seg_data, .bias_ctrl, .cpump_clk, .com_drive, .com_release, .seg_drive,
    .drive_polarity, .com_index);
  lcd_glass_model #(.COM_N(8)) glass (.aclk, .com_drive, .seq_err, .frame_coms, .dwell);

  // ==========================================================
  // Clocks; sub clock is free running and much faster than real to keep runs short
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) sub_cnt <= sub_cnt + 2'h1;
  assign sub_clk = sub_cnt[1];

  // ==========================================================
  // Compare, finish and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(inout int k);
    @(posedge aclk);
    k++;
    if (k > 500) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      tick(k);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(k);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [3:0] adr(input int r);
    return r == 0 ? `LCD_ADDR_MAIN : (r == 1 ? `LCD_ADDR_PUMP : `LCD_ADDR_DUTY);
  endfunction
  function automatic logic [7:0] msk(input int r);
    return r == 0 ? 8'hf7 : (r == 1 ? 8'h0b : 8'he7);
  endfunction
  task automatic setr(input int r, input logic [7:0] d);
    wr(adr(r), d, 4'hf);
    regs[r] = d & msk(r);
  endtask
  task automatic half(output int w);
    logic p;
    for (int q = 0; q < 2; q++) begin
      p = cpump_clk;
      w = 0;
      do begin
        tick(w);
      end while (cpump_clk === p);
    end
  endtask
  function automatic bias_ctrl_t exp_bias(input logic [7:0] m, input logic [7:0] p,
                                          input logic [7:0] d, input logic s);
    bias_ctrl_t b;
    b.wave_type_b = m[7];
    b.cbias_selected = m[6];
    b.cbias_power_source = m[5:4];
    b.rbias_current_select = m[2:1];
    b.rbias_supply_select = p[3];
    b.rpump_enable = p[3] && !m[6] && m[0] && !s;
    b.cpump_enable = m[6];
    b.pump_voltage_select = p[1:0];
    b.bias_quarter = d[0];
    return b;
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h9e77;
    {bad_count, n_checks} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, sleep_mode, sub_cnt} = '0;
    seg_data = 32'h0;
    regs = '{8'h0, 8'h0, 8'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rdr(adr(r));
      check(rd, 32'h0); // Reset value
    end
    for (int j = 0; j < 30; j++) begin
      i = j % 3;
      v = 8'($random(seed));
      // current held zero under pump bias
      if (i == 0 && v[6]) v[2:1] = 2'h0;
      setr(i, v);
      check(resp, `LCD_AXI_OKAY); // Write accepted
      rdr(adr(i));
      check(rd, {24'h0, regs[i]}); // Masked readback
      sleep_mode <= 1'($random(seed));
      repeat (2) @(posedge aclk);
      check(bias_ctrl, exp_bias(regs[0], regs[1], regs[2], sleep_mode));
    end
    wr(4'hc, 8'hff, 4'hf);
    check(resp, `LCD_AXI_SLVERR); // Unmapped write
    rdr(4'hc);
    check(rd, 32'h0); // Unmapped read
    check(resp, `LCD_AXI_SLVERR); // Unmapped read
    wr(adr(1), ~regs[1], 4'h0);
    rdr(adr(1));
    check(rd, {24'h0, regs[1]}); // Strobe off keeps value
    $display("test registers done");
    sleep_mode <= 1'b0;
    seg_data <= $random(seed);
    for (int c = 0; c < 4; c++) begin
      setr(0, 8'h00);
      setr(2, 8'(c << 1));
      repeat (2) @(posedge aclk);
      check(com_release, c == 1 ? 8'hc0 : (c == 2 ? 8'h00 : 8'hf0)); // Unused commons
      check(com_drive, 8'h0); // Disabled blank
      setr(0, 8'h01);
      repeat (24 * 16 * SUBP) @(posedge aclk);
      check(frame_coms, c == 1 ? 6 : (c == 2 ? 8 : 4)); // Commons per frame
      check(dwell, 2 * 8 * SUBP); // Two steps of eight sub edges per common
      check(seg_drive, seg_data); // Segments follow data
    end
    check(seq_err, 0); // Scan order
    sleep_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    check(|{com_drive, seg_drive, com_index, drive_polarity}, 1'b0); // Sleep blanks
    sleep_mode <= 1'b0;
    repeat (200) @(posedge aclk);
    check(|com_drive, 1'b1); // Running again
    setr(0, 8'h00);
    repeat (2) @(posedge aclk);
    check(|{com_drive, seg_drive, com_index, drive_polarity}, 1'b0); // Enable off blanks
    $display("test scan done");
    setr(2, 8'h00);
    repeat (600) @(posedge aclk);
    check(cpump_clk, 1'b0); // Pump clock idle
    setr(0, 8'h41);
    for (int c = 0; c < 8; c++) begin
      setr(2, 8'(c << 5));
      half(n);
      check(n, (64 >> (c == 7 ? 6 : c)) * SUBP); // Pump divider
    end
    $display("test pump done");
    close_out();
  end
endmodule // segment_lcd_control_regs_tb
